// ---- hdl/intruder_alarm_controller.sv ----
// Functional notes
// - codes idle 111, exit 001, armed 101, entry 011, sound 010, hold 100.
// - reset sets all state bits and the sounder to one: disarmed, silent.
// - the delay counter is cleared while counter_hold_bit is one.
// - a high detector means alarm; sounder and beacon are active low.
// - disarmed: fire or attack to hold sounding, else arm to exit_delay.
// - exit_delay: fire to hold sounding; short tap with arm or reset arms.
// - armed: fire to hold, instant zone to sounding, delayed to entry_delay.
// - entry_delay: fire to hold; short tap or instant zone to sounding.
// - sounding: fire to hold on; long tap with arm or reset to hold off.
// - tap bit 7 times entry and exit, tap bit 10 times sounder cutoff.
// - arm and reset both low disarm silently; hold_alarm has no other exit.
// - each detector's sense may be inverted by a build parameter.
// - a transition without a sounder value leaves the sounder alone.
// - the delay counter is a 10-bit binary up-counter with a bit-7 tap.
`timescale 1ns/1ps
`default_nettype none

module intruder_alarm_controller
    import alarm_pkg::*;
#(
    parameter logic [NUM_DETECT-1:0] INVERT = INVERT_NONE,
    parameter int TICK_DIV = TICK_CYCLES
) (
    // clock and reset
    input wire logic clock,
    input wire logic arst_n,
    // control switches
    input wire logic arm,
    input wire logic reset,
    // detectors
    input wire logic fire,
    input wire logic personal_attack_in,
    input wire logic delayed_zone_a,
    input wire logic delayed_zone_b,
    input wire logic instant_zone_a,
    input wire logic instant_zone_b,
    input wire logic instant_zone_c,
    // drivers, active low
    output logic sounder_n,
    output logic beacon_n,
    // state and delay taps
    output logic counter_hold_bit,
    output logic state_select_bit,
    output logic delay_tap_short
);
    logic [NUM_DETECT-1:0] raw;
    logic [NUM_DETECT-1:0] act;
    logic [2:0] code_q;
    logic [2:0] code_d;
    logic sounder_q;
    logic sounder_d;
    logic [31:0] div_q;
    logic tick;
    alarm_state_e state;
    alarm_state_e next_state;
    logic next_sound_set;
    logic next_sound_val;

    delay_if dly();

    // ------------------------------------------------------------
    // state code decoding
    // ------------------------------------------------------------
    function automatic alarm_state_e decode_state(input logic [2:0] c);
        case (c)
            ST_CODE_EXIT: decode_state = exit_delay;
            ST_CODE_ARMED: decode_state = armed;
            ST_CODE_ENTRY: decode_state = entry_delay;
            ST_CODE_SOUNDING: decode_state = sounding;
            ST_CODE_HOLD: decode_state = hold_alarm;
            default: decode_state = disarmed;
        endcase
    endfunction : decode_state

    function automatic logic [2:0] encode_state(input alarm_state_e s);
        case (s)
            exit_delay: encode_state = ST_CODE_EXIT;
            armed: encode_state = ST_CODE_ARMED;
            entry_delay: encode_state = ST_CODE_ENTRY;
            sounding: encode_state = ST_CODE_SOUNDING;
            hold_alarm: encode_state = ST_CODE_HOLD;
            default: encode_state = ST_CODE_DISARMED;
        endcase
    endfunction : encode_state

    // ------------------------------------------------------------
    // input synchronisers with sense inversion
    // ------------------------------------------------------------
    assign raw = {instant_zone_c, instant_zone_b, instant_zone_a,
        delayed_zone_b, delayed_zone_a, personal_attack_in, fire,
        reset, arm};

    detect_sync #(.INVERT(INVERT)) u_sync (
        .clock(clock),
        .arst_n(arst_n),
        .raw(raw),
        .active(act)
    );

    wire logic a_arm = act[DET_ARM];
    wire logic a_reset = act[DET_RESET];
    wire logic a_fire = act[DET_FIRE];
    wire logic a_attack = act[DET_ATTACK];
    wire logic a_delayed = act[DET_DLY_A] | act[DET_DLY_B];
    wire logic a_instant = act[DET_INST_A] | act[DET_INST_B]
        | act[DET_INST_C];
    wire logic disarm_req = !a_arm && !a_reset;
    wire logic keep_on = a_arm || a_reset;

    // ------------------------------------------------------------
    // slow tick divider: one-cycle enable about 4 Hz
    // ------------------------------------------------------------
    assign tick = (div_q == 32'(TICK_DIV - 1));

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            div_q <= 32'h0;
        end else begin
            div_q <= tick ? 32'h0 : div_q + 32'h1;
        end
    end

    // ------------------------------------------------------------
    // delay counter
    // ------------------------------------------------------------
    assign dly.hold = code_q[HOLD_BIT_POS];
    assign dly.tick = tick;

    delay_counter u_delay (
        .clock(clock),
        .arst_n(arst_n),
        .dly(dly.cnt)
    );

    // ------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------
    assign state = decode_state(code_q);

    always_comb begin
        next_state = state;
        next_sound_set = 1'b0;
        next_sound_val = SOUNDER_OFF;
        case (state)
            disarmed: begin
                if (a_fire || a_attack) begin
                    next_state = hold_alarm;
                    next_sound_set = 1'b1;
                    next_sound_val = SOUNDER_ON;
                end else if (a_arm) begin
                    next_state = exit_delay;
                end
            end
            default: begin
                if (a_fire) begin
                    next_state = hold_alarm;
                    next_sound_set = 1'b1;
                    next_sound_val = SOUNDER_ON;
                end else if (disarm_req) begin
                    next_state = disarmed;
                    next_sound_set = 1'b1;
                    next_sound_val = SOUNDER_OFF;
                end else begin
                    case (state)
                        exit_delay: begin
                            if (dly.tap_short && keep_on) begin
                                next_state = armed;
                            end
                        end
                        armed: begin
                            if (a_instant) begin
                                next_state = sounding;
                                next_sound_set = 1'b1;
                                next_sound_val = SOUNDER_ON;
                            end else if (a_delayed) begin
                                next_state = entry_delay;
                            end
                        end
                        entry_delay: begin
                            if (dly.tap_short || a_instant) begin
                                next_state = sounding;
                                next_sound_set = 1'b1;
                                next_sound_val = SOUNDER_ON;
                            end
                        end
                        sounding: begin
                            if (dly.tap_long && keep_on) begin
                                next_state = hold_alarm;
                                next_sound_set = 1'b1;
                                next_sound_val = SOUNDER_OFF;
                            end
                        end
                        default: begin
                            next_state = state;
                        end
                    endcase
                end
            end
        endcase
    end

    assign code_d = encode_state(next_state);
    assign sounder_d = next_sound_set ? next_sound_val : sounder_q;

    // ------------------------------------------------------------
    // state and sounder registers, preset high
    // ------------------------------------------------------------
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            code_q <= STATE_RESET;
            sounder_q <= SOUNDER_RESET;
        end else begin
            code_q <= code_d;
            sounder_q <= sounder_d;
        end
    end

    assign sounder_n = sounder_q;
    assign beacon_n = code_q[BEACON_POS];
    assign counter_hold_bit = code_q[HOLD_BIT_POS];
    assign state_select_bit = code_q[SELECT_BIT_POS];
    assign delay_tap_short = dly.tap_short;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence fire_seen;
        a_fire;
    endsequence

    sequence hold_sounding;
        code_q == ST_CODE_HOLD && sounder_q == SOUNDER_ON;
    endsequence

    sequence sounding_on;
        code_q == ST_CODE_SOUNDING && sounder_q == SOUNDER_ON;
    endsequence

    legal_code_a: assert property (
        @(posedge clock) disable iff (!arst_n)
        code_q != 3'h0 && code_q != 3'h6)
        else $error("illegal state code");
    fire_hold_a: assert property (
        @(posedge clock) disable iff (!arst_n)
        fire_seen |=> hold_sounding)
        else $error("fire did not force hold with sounder");
    attack_hold_a: assert property (
        @(posedge clock) disable iff (!arst_n)
        state == disarmed && a_attack |=> hold_sounding)
        else $error("attack did not force hold with sounder");
    arm_exit_a: assert property (
        @(posedge clock) disable iff (!arst_n)
        state == disarmed && a_arm && !a_fire && !a_attack
        |=> code_q == ST_CODE_EXIT)
        else $error("arm did not start exit delay");
    quiet_arm_a: assert property (
        @(posedge clock) disable iff (!arst_n)
        state == disarmed && a_arm && !a_fire && !a_attack
        |=> $stable(sounder_q))
        else $error("arming changed the sounder");
    exit_armed_a: assert property (
        @(posedge clock) disable iff (!arst_n)
        state == exit_delay && dly.tap_short && !a_fire && keep_on
        |=> code_q == ST_CODE_ARMED)
        else $error("exit delay did not arm");
    armed_entry_a: assert property (
        @(posedge clock) disable iff (!arst_n)
        state == armed && a_delayed && !a_instant && !a_fire && keep_on
        |=> code_q == ST_CODE_ENTRY && sounder_q == $past(sounder_q))
        else $error("delayed zone did not start entry delay");
    armed_sound_a: assert property (
        @(posedge clock) disable iff (!arst_n)
        state == armed && a_instant && !a_fire && keep_on
        |=> sounding_on)
        else $error("instant zone did not sound when armed");
    entry_sound_a: assert property (
        @(posedge clock) disable iff (!arst_n)
        state == entry_delay && dly.tap_short && !a_fire && keep_on
        |=> code_q == ST_CODE_SOUNDING && sounder_q == SOUNDER_ON)
        else $error("entry delay expiry did not sound");
    entry_zone_a: assert property (
        @(posedge clock) disable iff (!arst_n)
        state == entry_delay && a_instant && !a_fire && keep_on
        |=> sounding_on)
        else $error("instant zone did not sound in entry delay");
    cutoff_a: assert property (
        @(posedge clock) disable iff (!arst_n)
        state == sounding && dly.tap_long && !a_fire && keep_on
        |=> code_q == ST_CODE_HOLD && sounder_q == SOUNDER_OFF)
        else $error("sounder cutoff missed");
    disarm_a: assert property (
        @(posedge clock) disable iff (!arst_n)
        state != disarmed && disarm_req && !a_fire
        |=> code_q == ST_CODE_DISARMED && sounder_q == SOUNDER_OFF)
        else $error("disarm did not return to disarmed");
    hold_stays_a: assert property (
        @(posedge clock) disable iff (!arst_n)
        state == hold_alarm && keep_on && !a_fire |=> state == hold_alarm)
        else $error("hold_alarm left without disarm");
endmodule : intruder_alarm_controller

`default_nettype wire

// ---- hdl/alarm_pkg.sv ----
package alarm_pkg;

    // ------------------------------------------------------------
    // state encoding {counter_hold_bit, state_select_bit, beacon}
    // ------------------------------------------------------------
    localparam logic [2:0] ST_CODE_DISARMED = 3'h7;
    localparam logic [2:0] ST_CODE_EXIT = 3'h1;
    localparam logic [2:0] ST_CODE_ARMED = 3'h5;
    localparam logic [2:0] ST_CODE_ENTRY = 3'h3;
    localparam logic [2:0] ST_CODE_SOUNDING = 3'h2;
    localparam logic [2:0] ST_CODE_HOLD = 3'h4;
    localparam int HOLD_BIT_POS = 2;
    localparam int SELECT_BIT_POS = 1;
    localparam int BEACON_POS = 0;

    // ------------------------------------------------------------
    // sounder levels and reset values
    // ------------------------------------------------------------
    localparam logic SOUNDER_ON = 1'h0;
    localparam logic SOUNDER_OFF = 1'h1;
    localparam logic [2:0] STATE_RESET = 3'h7;
    localparam logic SOUNDER_RESET = 1'h1;

    // ------------------------------------------------------------
    // delay counter layout
    // ------------------------------------------------------------
    localparam int DELAY_WIDTH = 10;
    localparam int TAP_SHORT_POS = 6;
    localparam int TAP_LONG_POS = 9;
    localparam logic [9:0] DELAY_RESET = 10'h000;
    localparam logic [9:0] DELAY_ONE = 10'h001;
    // tap bit n (1-based) first rises after 2**(n-1) slow ticks
    localparam int SHORT_TICKS = 64;
    localparam int LONG_TICKS = 512;

    // ------------------------------------------------------------
    // detector input vector positions
    // ------------------------------------------------------------
    localparam int NUM_DETECT = 9;
    localparam int DET_ARM = 0;
    localparam int DET_RESET = 1;
    localparam int DET_FIRE = 2;
    localparam int DET_ATTACK = 3;
    localparam int DET_DLY_A = 4;
    localparam int DET_DLY_B = 5;
    localparam int DET_INST_A = 6;
    localparam int DET_INST_B = 7;
    localparam int DET_INST_C = 8;
    localparam logic [8:0] INVERT_NONE = 9'h000;

    // ------------------------------------------------------------
    // slow tick: 100 MHz down to about 4 Hz
    // ------------------------------------------------------------
    localparam int CLOCK_HZ = 100000000;
    localparam int TICK_HZ = 4;
    localparam int TICK_CYCLES = CLOCK_HZ / TICK_HZ;

    typedef enum {
        disarmed,
        exit_delay,
        armed,
        entry_delay,
        sounding,
        hold_alarm
    } alarm_state_e;

endpackage : alarm_pkg

// ---- hdl/delay_if.sv ----
`timescale 1ns/1ps
`default_nettype none

interface delay_if;
    import alarm_pkg::*;
    logic hold;
    logic tick;
    logic tap_short;
    logic tap_long;
    logic [DELAY_WIDTH-1:0] count;

    modport ctrl (output hold, output tick, input tap_short,
        input tap_long, input count);
    modport cnt (input hold, input tick, output tap_short,
        output tap_long, output count);
endinterface : delay_if

`default_nettype wire

// ---- hdl/detect_sync.sv ----
`timescale 1ns/1ps
`default_nettype none

module detect_sync
    import alarm_pkg::*;
#(
    parameter logic [NUM_DETECT-1:0] INVERT = INVERT_NONE
) (
    // clock and reset
    input wire logic clock,
    input wire logic arst_n,
    // raw pins and alarm-true levels
    input wire logic [NUM_DETECT-1:0] raw,
    output logic [NUM_DETECT-1:0] active
);
    logic [NUM_DETECT-1:0] meta_q;
    logic [NUM_DETECT-1:0] sync_q;

    // ------------------------------------------------------------
    // two-stage synchroniser per pin
    // ------------------------------------------------------------
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            // preset to the idle pin level so no false alarm follows reset
            meta_q <= INVERT;
            sync_q <= INVERT;
        end else begin
            meta_q <= raw;
            sync_q <= meta_q;
        end
    end

    // build-time sense inversion per detector
    assign active = sync_q ^ INVERT;
endmodule : detect_sync

`default_nettype wire

// ---- hdl/delay_counter.sv ----
`timescale 1ns/1ps
`default_nettype none

module delay_counter
    import alarm_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic arst_n,
    // controller side
    delay_if.cnt dly
);
    logic [DELAY_WIDTH-1:0] count_q;
    logic [DELAY_WIDTH-1:0] count_d;

    // ------------------------------------------------------------
    // 10-bit binary up-counter, cleared while held
    // ------------------------------------------------------------
    assign count_d = dly.hold ? DELAY_RESET :
        (dly.tick ? count_q + DELAY_ONE : count_q);

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            count_q <= DELAY_RESET;
        end else begin
            count_q <= count_d;
        end
    end

    assign dly.count = count_q;
    assign dly.tap_short = count_q[TAP_SHORT_POS];
    assign dly.tap_long = count_q[TAP_LONG_POS];

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    held_clear_a: assert property (
        @(posedge clock) disable iff (!arst_n)
        dly.hold |=> count_q == DELAY_RESET)
        else $error("delay counter not cleared while held");
    counts_tick_a: assert property (
        @(posedge clock) disable iff (!arst_n)
        !dly.hold && dly.tick |=> count_q == $past(count_q) + DELAY_ONE)
        else $error("delay counter did not advance");
endmodule : delay_counter

`default_nettype wire

// ---- testbench/alarm_field.sv ----
`timescale 1ns/1ps
`default_nettype none

module alarm_field
    import alarm_pkg::*;
#(
    parameter logic [NUM_DETECT-1:0] INVERT = INVERT_NONE
) (
    // alarm-true levels asked for by the bench
    input wire logic [NUM_DETECT-1:0] want,
    // pin levels as the switches and transducers drive them
    output logic arm,
    output logic reset,
    output logic fire,
    output logic personal_attack_in,
    output logic delayed_zone_a,
    output logic delayed_zone_b,
    output logic instant_zone_a,
    output logic instant_zone_b,
    output logic instant_zone_c
);
    // --------------------------------------------------------
    // low-alarm transducers drive the inverse level
    // --------------------------------------------------------
    wire [NUM_DETECT-1:0] pins = want ^ INVERT;

    assign arm = pins[DET_ARM];
    assign reset = pins[DET_RESET];
    assign fire = pins[DET_FIRE];
    assign personal_attack_in = pins[DET_ATTACK];
    assign delayed_zone_a = pins[DET_DLY_A];
    assign delayed_zone_b = pins[DET_DLY_B];
    assign instant_zone_a = pins[DET_INST_A];
    assign instant_zone_b = pins[DET_INST_B];
    assign instant_zone_c = pins[DET_INST_C];
endmodule : alarm_field

`default_nettype wire

// ---- testbench/intruder_alarm_controller_bench.sv ----
`timescale 1ns/1ps
`default_nettype none

module intruder_alarm_controller_bench;
    import alarm_pkg::*;

    // --------------------------------------------------------
    // setup
    // --------------------------------------------------------
    localparam int TD = 2;
    localparam logic [8:0] INV = 9'h004;
    localparam int SLO = 64 * TD - 8;
    localparam int SHI = 64 * TD + TD + 2;
    // the counter runs on from the entry delay, so sounding is shorter
    localparam int SND_LO = (LONG_TICKS - SHORT_TICKS) * TD - 4;
    localparam int SND_HI = (LONG_TICKS - SHORT_TICKS) * TD + TD + 2;
    logic clock = 1'h0;
    logic arst_n = 1'h0;
    logic [8:0] want = 9'h000;
    logic arm, reset, fire, attack, dly_a, dly_b, ins_a, ins_b, ins_c;
    logic sounder_n, beacon_n, hold_bit, sel_bit, tap;
    logic [8:0] v;
    logic [3:0] exp_v;
    int failures = 0;
    int checks = 0;
    wire [3:0] seen = {hold_bit, sel_bit, beacon_n, sounder_n};

    alarm_field #(.INVERT(INV)) i_field (
        .want(want), .arm(arm), .reset(reset), .fire(fire),
        .personal_attack_in(attack), .delayed_zone_a(dly_a),
        .delayed_zone_b(dly_b), .instant_zone_a(ins_a),
        .instant_zone_b(ins_b), .instant_zone_c(ins_c)
    );

    intruder_alarm_controller #(.INVERT(INV), .TICK_DIV(TD)) i_dut (
        .clock(clock), .arst_n(arst_n), .arm(arm), .reset(reset),
        .fire(fire), .personal_attack_in(attack),
        .delayed_zone_a(dly_a), .delayed_zone_b(dly_b),
        .instant_zone_a(ins_a), .instant_zone_b(ins_b),
        .instant_zone_c(ins_c), .sounder_n(sounder_n),
        .beacon_n(beacon_n), .counter_hold_bit(hold_bit),
        .state_select_bit(sel_bit), .delay_tap_short(tap)
    );

    // --------------------------------------------------------
    // helpers
    // --------------------------------------------------------
    task automatic end_sim();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : end_sim

    task automatic check(input logic [3:0] got, input logic [3:0] exp);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("BAD t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : check

    task automatic drive(input logic [8:0] val);
        @(posedge clock);
        want <= val;
    endtask : drive

    // state moves three edges after a pin change
    task automatic settle(input logic [3:0] exp);
        repeat (3) @(posedge clock);
        #1;
        check(seen, exp);
    endtask : settle

    task automatic wait_state(input logic [2:0] code, input int lo,
            input int hi);
        int n;
        n = 0;
        while (seen[3:1] !== code && n < hi + 4) begin
            @(posedge clock);
            #1;
            n++;
        end
        checks++;
        if (n < lo || n > hi) begin
            failures++;
            $display("BAD t=%0t cycles %h exp %h", $time, n, lo);
        end
    endtask : wait_state

    task automatic go_armed();
        drive(9'h001);
        settle({ST_CODE_EXIT, SOUNDER_OFF});
        wait_state(ST_CODE_ARMED, SLO, SHI);
        @(posedge clock);
        #1;
        check({3'h0, tap}, 4'h0);
        check(seen, {ST_CODE_ARMED, SOUNDER_OFF});
    endtask : go_armed

    task automatic disarm();
        drive(9'h000);
        settle({ST_CODE_DISARMED, SOUNDER_OFF});
    endtask : disarm

    // next state and sounder from a held state, no taps involved
    function automatic logic [3:0] predict(input logic [3:0] s,
            input logic [8:0] a);
        if (a[DET_FIRE]) begin
            return {ST_CODE_HOLD, SOUNDER_ON};
        end
        if (s[3:1] != ST_CODE_DISARMED && !a[DET_ARM]
                && !a[DET_RESET]) begin
            return {ST_CODE_DISARMED, SOUNDER_OFF};
        end
        if (s[3:1] == ST_CODE_DISARMED) begin
            if (a[DET_ATTACK]) begin
                return {ST_CODE_HOLD, SOUNDER_ON};
            end
            if (a[DET_ARM]) begin
                return {ST_CODE_EXIT, s[0]};
            end
        end
        if (s[3:1] == ST_CODE_ARMED) begin
            if (|a[8:6]) begin
                return {ST_CODE_SOUNDING, SOUNDER_ON};
            end
            if (|a[5:4]) begin
                return {ST_CODE_ENTRY, s[0]};
            end
        end
        return s;
    endfunction : predict

    // --------------------------------------------------------
    // clock, watchdog, tests
    // --------------------------------------------------------
    initial begin
        forever #5 clock = ~clock;
    end

    initial begin
        repeat (100000) @(posedge clock);
        failures++;
        end_sim();
    end

    initial begin
        void'($urandom(32'h2d3f585c));
        repeat (4) @(posedge clock);
        #1;
        check(seen, 4'hf);
        repeat (4) @(posedge clock);
        arst_n <= 1'h1;
        repeat (2) @(posedge clock);
        #1;
        check({tap, seen[3:1]}, {1'h0, STATE_RESET});
        // full intrusion path with delays
        go_armed();
        drive(9'h011);
        settle({ST_CODE_ENTRY, SOUNDER_OFF});
        wait_state(ST_CODE_SOUNDING, SLO, SHI);
        check(seen, {ST_CODE_SOUNDING, SOUNDER_ON});
        wait_state(ST_CODE_HOLD, SND_LO, SND_HI);
        check(seen, {ST_CODE_HOLD, SOUNDER_OFF});
        drive(9'h002);
        repeat (20) @(posedge clock);
        #1;
        check(seen, {ST_CODE_HOLD, SOUNDER_OFF});
        disarm();
        // exit held by reset alone, instant beats delayed
        drive(9'h001);
        settle({ST_CODE_EXIT, SOUNDER_OFF});
        drive(9'h002);
        wait_state(ST_CODE_ARMED, SLO, SHI);
        drive(9'h0a1);
        settle({ST_CODE_SOUNDING, SOUNDER_ON});
        drive(9'h004);
        settle({ST_CODE_HOLD, SOUNDER_ON});
        disarm();
        // exit: fire, then plain disarm
        drive(9'h001);
        settle({ST_CODE_EXIT, SOUNDER_OFF});
        drive(9'h005);
        settle({ST_CODE_HOLD, SOUNDER_ON});
        disarm();
        drive(9'h001);
        settle({ST_CODE_EXIT, SOUNDER_OFF});
        disarm();
        // attack ignored when armed, instant zone in entry
        go_armed();
        drive(9'h009);
        settle({ST_CODE_ARMED, SOUNDER_OFF});
        drive(9'h019);
        settle({ST_CODE_ENTRY, SOUNDER_OFF});
        drive(9'h119);
        settle({ST_CODE_SOUNDING, SOUNDER_ON});
        drive(9'h11d);
        settle({ST_CODE_HOLD, SOUNDER_ON});
        disarm();
        // random detector patterns from held states
        for (int i = 0; i < 30; i++) begin
            if ($urandom % 2) begin
                go_armed();
            end
            v = 9'($urandom);
            exp_v = predict(seen, v);
            drive(v);
            settle(exp_v);
            disarm();
        end
        end_sim();
    end
endmodule : intruder_alarm_controller_bench

`default_nettype wire
